// ==== rtl/usp_bit_sampler.sv ====
// Purpose: Divide-by-16 bit timer with three-sample majority vote
// Assumes: tick is one pclk cycle wide at 16x the bit rate
// Notes: Result pulses one cycle after the third sample

`timescale 1ns/100ps
module usp_bit_sampler (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic restart,
    input wire logic tick,
    input wire logic line,
    output usp_pkg::usp_bit_type bit_o
);
    import usp_pkg::*;

    logic [3:0] cnt_q;
    logic [1:0] samp_q;
    usp_bit_type bit_q;

    // ==========================================================
    // Bit-time counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= 4'h0;
        else if (restart)
            cnt_q <= 4'h0;
        else if (tick)
            cnt_q <= cnt_q + 4'h1;
    end

    // ==========================================================
    // Samples and vote
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            samp_q <= 2'b00;
            bit_q <= '0;
        end
        else
        begin
            bit_q.valid <= 1'b0;
            if (restart)
                samp_q <= 2'b00;
            else if (tick)
            begin
                if (cnt_q == SAMP_FIRST)
                    samp_q[0] <= line;
                if (cnt_q == SAMP_SECOND)
                    samp_q[1] <= line;
                if (cnt_q == SAMP_THIRD)
                begin
                    bit_q.valid <= 1'b1;
                    bit_q.value <= (samp_q[0] & samp_q[1]) | (samp_q[0] & line)
                        | (samp_q[1] & line);
                end
            end
        end
    end

    assign bit_o = bit_q;

endmodule

// ==== rtl/usp_serial_port.sv ====
// Purpose: Serial port with shift-register and UART modes behind APB
// Assumes: rxd_i synchronous to pclk; zero-wait APB slave
// Notes: Variable rate comes from the baud divider register
//
// Chosen here: the APB interface to the registers.

`timescale 1ns/100ps
module usp_serial_port (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd_i,
    output logic rxd_o,
    output logic rxd_oe,
    output logic txd_o
);
    import usp_pkg::*;

    typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} usp_tx_state_type;
    typedef enum logic {RX_IDLE, RX_FRAME} usp_rx_state_type;

    usp_ctrl_type ctrl_q;
    usp_mode_type mode;
    usp_tx_state_type tx_state_q;
    usp_rx_state_type rx_state_q;
    usp_bit_type bit_s;
    logic frame_error_flag_q;
    logic view_q;
    logic double_q;
    logic [15:0] baud_q;
    logic [15:0] baud_cnt_q;
    logic [15:0] tick_lim;
    logic samp_tick;
    logic [7:0] rbuf_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_word;
    logic addr_hit;
    logic wr_acc;
    logic wr_ctrl;
    logic wr_data;
    logic wr_pwr;
    logic wr_baud;
    logic [10:0] tx_sh_q;
    logic [3:0] tx_cnt_q;
    logic [3:0] tx_div_q;
    logic [2:0] sync_div_q;
    logic sync_rx_q;
    logic txd_q;
    logic rxo_q;
    logic rxoe_q;
    logic tx_bound;
    logic sync_end;
    logic sync_start;
    logic tx_set;
    logic sync_take;
    logic async_mode;
    logic rx_prev_q;
    logic [8:0] rx_sh_q;
    logic [3:0] rx_idx_q;
    logic [3:0] rx_last;
    logic rx_start;
    logic rx_final;
    logic rx_nine;
    logic async_take;
    logic frame_err_set;
    logic rx_take;
    logic [7:0] rx_data;

    // ==========================================================
    // Mode decode
    assign mode = usp_mode_type'({ctrl_q.mode_select_hi, ctrl_q.mode_select_lo});
    assign async_mode = (mode != MODE_SHIFT);

    // ==========================================================
    // APB slave
    assign pready = 1'b1;
    assign addr_hit = (paddr == CTRL_OFS) || (paddr == DATA_OFS)
        || (paddr == PWR_OFS) || (paddr == BAUD_OFS);
    assign pslverr = psel & penable & ~addr_hit;
    assign wr_acc = psel & penable & pwrite;
    assign wr_ctrl = wr_acc && (paddr == CTRL_OFS);
    assign wr_data = wr_acc && (paddr == DATA_OFS);
    assign wr_pwr = wr_acc && (paddr == PWR_OFS);
    assign wr_baud = wr_acc && (paddr == BAUD_OFS);

    always_comb
    begin
        rd_word = 32'h0000_0000;
        unique case (paddr)
            CTRL_OFS:
            begin
                rd_word[7:0] = ctrl_q;
                rd_word[CTRL_TOP_BIT] = view_q ? frame_error_flag_q : ctrl_q.mode_select_hi;
            end
            DATA_OFS:
                rd_word[7:0] = rbuf_q;
            PWR_OFS:
            begin
                rd_word[PWR_VIEW_BIT] = view_q;
                rd_word[PWR_DOUBLE_BIT] = double_q;
            end
            BAUD_OFS:
                rd_word[15:0] = baud_q;
            default:
                rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata_q <= rd_word;
    end

    assign prdata = prdata_q;

    // ==========================================================
    // Power control and baud divider
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            view_q <= PWR_BIT_RST;
            double_q <= PWR_BIT_RST;
            baud_q <= BAUD_RST;
        end
        else
        begin
            if (wr_pwr)
            begin
                view_q <= pwdata[PWR_VIEW_BIT];
                double_q <= pwdata[PWR_DOUBLE_BIT];
            end
            if (wr_baud)
                baud_q <= pwdata[15:0];
        end
    end

    // ==========================================================
    // Control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= usp_ctrl_type'(CTRL_RST);
        else
        begin
            if (wr_ctrl)
            begin
                if (!view_q)
                    ctrl_q.mode_select_hi <= pwdata[CTRL_TOP_BIT];
                ctrl_q[6:0] <= pwdata[6:0];
            end
            if (tx_set)
                ctrl_q.tx_done_flag <= 1'b1;
            if (rx_take)
                ctrl_q.rx_done_flag <= 1'b1;
            if (async_take)
                ctrl_q.rx_ninth_bit <= rx_nine;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            frame_error_flag_q <= 1'b0;
        else if (frame_err_set)
            frame_error_flag_q <= 1'b1;
        else if (wr_ctrl && view_q)
            frame_error_flag_q <= pwdata[CTRL_TOP_BIT];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rbuf_q <= 8'h00;
        else if (rx_take)
            rbuf_q <= rx_data;
    end

    // ==========================================================
    // Sample tick at 16x bit rate
    assign tick_lim = (mode == MODE_UART9_FIX) ? (double_q ? FIX_LIM_FAST : FIX_LIM_SLOW)
        : baud_q;
    assign samp_tick = (baud_cnt_q >= tick_lim);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            baud_cnt_q <= 16'h0000;
        else if (samp_tick)
            baud_cnt_q <= 16'h0000;
        else
            baud_cnt_q <= baud_cnt_q + 16'h0001;
    end

    // ==========================================================
    // Transmitter and shift-mode engine
    assign tx_bound = samp_tick && (tx_div_q == BIT_LAST_STATE);
    assign sync_end = (sync_div_q == SHIFT_DIV_LAST);
    assign sync_start = (tx_state_q == TX_IDLE) && !async_mode && ctrl_q.rx_enable
        && !ctrl_q.rx_done_flag && !wr_data;
    assign tx_set = ((tx_state_q == TX_ASYNC) && tx_bound && (tx_cnt_q == 4'h2))
        || ((tx_state_q == TX_SYNC) && !sync_rx_q && sync_end && (tx_cnt_q == 4'h1));
    assign sync_take = (tx_state_q == TX_SYNC) && sync_rx_q && sync_end
        && (tx_cnt_q == 4'h1);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_state_q <= TX_IDLE;
            tx_sh_q <= TX_SH_RST;
            tx_cnt_q <= 4'h0;
            tx_div_q <= 4'h0;
            sync_div_q <= 3'h0;
            sync_rx_q <= 1'b0;
            txd_q <= 1'b1;
            rxo_q <= 1'b1;
            rxoe_q <= 1'b0;
        end
        else if (wr_data)
        begin
            tx_div_q <= 4'h0;
            sync_div_q <= 3'h0;
            txd_q <= 1'b0;
            if (!async_mode)
            begin
                tx_state_q <= TX_SYNC;
                sync_rx_q <= 1'b0;
                tx_sh_q <= {3'b111, pwdata[7:0]};
                tx_cnt_q <= SYNC_BITS;
                rxo_q <= pwdata[0];
                rxoe_q <= 1'b1;
            end
            else
            begin
                tx_state_q <= TX_ASYNC;
                if (mode == MODE_UART8)
                begin
                    tx_sh_q <= {2'b11, pwdata[7:0], 1'b0};
                    tx_cnt_q <= FRAME8_BITS;
                end
                else
                begin
                    tx_sh_q <= {1'b1, ctrl_q.tx_ninth_bit, pwdata[7:0], 1'b0};
                    tx_cnt_q <= FRAME9_BITS;
                end
                rxoe_q <= 1'b0;
            end
        end
        else
        begin
            unique case (tx_state_q)
                TX_IDLE:
                begin
                    if (sync_start)
                    begin
                        tx_state_q <= TX_SYNC;
                        sync_rx_q <= 1'b1;
                        tx_cnt_q <= SYNC_BITS;
                        sync_div_q <= 3'h0;
                        txd_q <= 1'b0;
                        rxoe_q <= 1'b0;
                    end
                end
                TX_ASYNC:
                begin
                    if (samp_tick)
                        tx_div_q <= tx_div_q + 4'h1;
                    if (tx_bound)
                    begin
                        tx_sh_q <= {1'b1, tx_sh_q[10:1]};
                        tx_cnt_q <= tx_cnt_q - 4'h1;
                        txd_q <= tx_sh_q[1];
                        if (tx_cnt_q == 4'h1)
                        begin
                            tx_state_q <= TX_IDLE;
                            txd_q <= 1'b1;
                        end
                    end
                end
                TX_SYNC:
                begin
                    sync_div_q <= sync_end ? 3'h0 : sync_div_q + 3'h1;
                    if (sync_div_q == SHIFT_PRE_RISE)
                        txd_q <= 1'b1;
                    if (sync_rx_q && (sync_div_q == SHIFT_RISE))
                        tx_sh_q[7:0] <= {rxd_i, tx_sh_q[7:1]};
                    if (sync_end)
                    begin
                        txd_q <= 1'b0;
                        tx_cnt_q <= tx_cnt_q - 4'h1;
                        if (!sync_rx_q)
                        begin
                            tx_sh_q <= {1'b1, tx_sh_q[10:1]};
                            rxo_q <= tx_sh_q[1];
                        end
                        if (tx_cnt_q == 4'h1)
                        begin
                            tx_state_q <= TX_IDLE;
                            txd_q <= 1'b1;
                            rxo_q <= 1'b1;
                            rxoe_q <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    assign txd_o = txd_q;
    assign rxd_o = rxo_q;
    assign rxd_oe = rxoe_q;

    // ==========================================================
    // Asynchronous receiver
    assign rx_start = (rx_state_q == RX_IDLE) && async_mode && ctrl_q.rx_enable
        && samp_tick && rx_prev_q && !rxd_i;
    assign rx_last = (mode == MODE_UART8) ? FRAME8_BITS - 4'h1 : FRAME9_BITS - 4'h1;
    assign rx_final = (rx_state_q == RX_FRAME) && ctrl_q.rx_enable && async_mode
        && bit_s.valid && (rx_idx_q == rx_last);
    assign rx_nine = (mode == MODE_UART8) ? bit_s.value : rx_sh_q[8];
    assign async_take = rx_final && !ctrl_q.rx_done_flag
        && (!ctrl_q.multiproc_gate || rx_nine);
    assign frame_err_set = rx_final && !bit_s.value;
    assign rx_take = async_take || sync_take;
    assign rx_data = sync_take ? tx_sh_q[7:0]
        : ((mode == MODE_UART8) ? rx_sh_q[8:1] : rx_sh_q[7:0]);

    usp_bit_sampler u_sampler (
        .pclk(pclk),
        .presetn(presetn),
        .restart(rx_start),
        .tick(samp_tick),
        .line(rxd_i),
        .bit_o(bit_s)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_prev_q <= 1'b1;
        else if (samp_tick)
            rx_prev_q <= rxd_i;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_state_q <= RX_IDLE;
            rx_sh_q <= 9'h000;
            rx_idx_q <= 4'h0;
        end
        else
        begin
            unique case (rx_state_q)
                RX_IDLE:
                begin
                    if (rx_start)
                    begin
                        rx_state_q <= RX_FRAME;
                        rx_idx_q <= 4'h0;
                    end
                end
                RX_FRAME:
                begin
                    if (!ctrl_q.rx_enable || !async_mode)
                        rx_state_q <= RX_IDLE;
                    else if (bit_s.valid)
                    begin
                        if ((rx_idx_q == 4'h0) && bit_s.value)
                            rx_state_q <= RX_IDLE;
                        else if (rx_idx_q == rx_last)
                            rx_state_q <= RX_IDLE;
                        else
                        begin
                            rx_idx_q <= rx_idx_q + 4'h1;
                            if (rx_idx_q != 4'h0)
                                rx_sh_q <= {bit_s.value, rx_sh_q[8:1]};
                        end
                    end
                end
            endcase
        end
    end

endmodule

// ==== shared/usp_pkg.sv ====
// Purpose: Constants, modes and carriers of the serial port
// Assumes: APB with byte addresses, 32-bit data
// Notes: Register layouts follow the control register bit order

// ==========================================================
// Package
package usp_pkg;

    // ==========================================================
    // Register map
    localparam logic [11:0] CTRL_OFS = 12'h098;
    localparam logic [11:0] DATA_OFS = 12'h09c;
    localparam logic [11:0] PWR_OFS = 12'h0a0;
    localparam logic [11:0] BAUD_OFS = 12'h0a4;

    // ==========================================================
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic PWR_BIT_RST = 1'b0;
    localparam logic [15:0] BAUD_RST = 16'h0000;
    localparam logic [10:0] TX_SH_RST = 11'h7ff;

    // ==========================================================
    // Field positions
    localparam int unsigned CTRL_TOP_BIT = 7;
    localparam int unsigned PWR_VIEW_BIT = 6;
    localparam int unsigned PWR_DOUBLE_BIT = 7;

    // ==========================================================
    // Timing counts
    localparam logic [3:0] SAMP_FIRST = 4'h7;
    localparam logic [3:0] SAMP_SECOND = 4'h8;
    localparam logic [3:0] SAMP_THIRD = 4'h9;
    localparam logic [3:0] BIT_LAST_STATE = 4'hf;
    localparam logic [2:0] SHIFT_DIV_LAST = 3'h5;
    localparam logic [2:0] SHIFT_PRE_RISE = 3'h2;
    localparam logic [2:0] SHIFT_RISE = 3'h3;
    localparam logic [15:0] FIX_LIM_SLOW = 16'h0001;
    localparam logic [15:0] FIX_LIM_FAST = 16'h0000;

    // ==========================================================
    // Frame lengths
    localparam logic [3:0] SYNC_BITS = 4'h8;
    localparam logic [3:0] FRAME8_BITS = 4'ha;
    localparam logic [3:0] FRAME9_BITS = 4'hb;

    // ==========================================================
    // Modes
    typedef enum logic [1:0]
    {
        MODE_SHIFT = 2'b00,
        MODE_UART8 = 2'b01,
        MODE_UART9_FIX = 2'b10,
        MODE_UART9_VAR = 2'b11
    } usp_mode_type;

    // ==========================================================
    // Carriers
    typedef struct packed
    {
        logic mode_select_hi;
        logic mode_select_lo;
        logic multiproc_gate;
        logic rx_enable;
        logic tx_ninth_bit;
        logic rx_ninth_bit;
        logic tx_done_flag;
        logic rx_done_flag;
    } usp_ctrl_type;

    typedef struct packed
    {
        logic valid;
        logic value;
    } usp_bit_type;

endpackage

// ==== verification/usp_remote_model.sv ====
// Purpose: Remote serial end on the receive and transmit lines
// Assumes: Receive line idles high from drv when the port does not drive it
// Notes: Bit length given per call in pclk cycles
`timescale 1ns/100ps
module usp_remote_model (
    input wire logic pclk,
    input wire logic txd,
    input wire logic line,
    output logic drv
);
    initial drv = 1'b1;

    // ==========================================================
    // Frame sender, LSB first, then idle high
    task automatic send(input logic [10:0] fr, input int n, input int len);
        for (int i = 0; i < n; i++)
            repeat (len) @(posedge pclk) drv <= fr[i];
        @(posedge pclk) drv <= 1'b1;
    endtask

    task automatic wait_lvl(input logic v);
        int t = 0;
        while (txd !== v && t < 3000)
        begin
            @(posedge pclk);
            t++;
        end
    endtask

    // ==========================================================
    // Frame receiver, sampling bit centres
    task automatic recv(input int n, input int len, output logic [10:0] fr);
        fr = '0;
        wait_lvl(1'b0);
        repeat (len / 2) @(posedge pclk);
        for (int i = 0; i < n; i++)
        begin
            fr[i] = txd;
            repeat (len) @(posedge pclk);
        end
    endtask

    // Shift mode data set after each clock fall
    task automatic send_shift(input logic [7:0] b);
        for (int i = 0; i < 8; i++)
        begin
            wait_lvl(1'b0);
            drv <= b[i];
            wait_lvl(1'b1);
        end
        @(posedge pclk) drv <= 1'b1;
    endtask

    // Shift mode data taken at clock rise
    task automatic recv_shift(output logic [10:0] fr);
        fr = '0;
        for (int i = 0; i < 8; i++)
        begin
            wait_lvl(1'b0);
            wait_lvl(1'b1);
            fr[i] = line;
        end
    endtask
endmodule

// ==== verification/usp_serial_port_asserts.sv ====
// Purpose: Port-level checks of the serial port
// Assumes: Zero-wait APB slave
// Notes: Mode is tracked from control writes
`timescale 1ns/100ps
module usp_serial_port_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rxd_o,
    input wire logic rxd_oe,
    input wire logic txd_o
);
    import usp_pkg::*;
    logic [1:0] mode_q;
    logic view_q;
    logic acc;
    logic map;
    assign acc = psel && penable;
    assign map = paddr inside {CTRL_OFS, DATA_OFS, PWR_OFS, BAUD_OFS};

    // ==========================================================
    // Mode tracking
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_q <= 2'b00;
            view_q <= 1'b0;
        end
        else if (acc && pwrite)
        begin
            if (paddr == CTRL_OFS)
                mode_q <= {view_q ? mode_q[1] : pwdata[7], pwdata[6]};
            if (paddr == PWR_OFS)
                view_q <= pwdata[PWR_VIEW_BIT];
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_ready_zero_wait: assert property (acc |-> pready)
        else $error("pready low in access phase");
    a_err_on_unmapped: assert property (acc |-> pslverr == !map)
        else $error("pslverr does not follow address map");
    a_rdata_upper_zero: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("read data upper bits not zero");
    a_rdata_unmapped: assert property (acc && !pwrite && !map |-> prdata == 32'h0)
        else $error("unmapped read data not zero");
    a_tx_start_bit: assert property (
        acc && pwrite && paddr == DATA_OFS && mode_q != 2'b00 |=> !txd_o)
        else $error("no start bit after data write");
    a_shift_clock_shape: assert property (
        $fell(txd_o) && mode_q == 2'b00 |-> !txd_o [*3] ##1 txd_o)
        else $error("shift clock low phase not three cycles");
    a_oe_shift_only: assert property (rxd_oe |-> mode_q == 2'b00)
        else $error("receive line driven outside shift mode");
    a_rxd_with_fall: assert property (
        rxd_oe && $past(rxd_oe) && $changed(rxd_o) |-> $fell(txd_o))
        else $error("shift data changed off clock fall");
    a_idle_after_reset: assert property ($rose(presetn) |-> txd_o && !rxd_oe)
        else $error("lines not idle after reset");
endmodule

bind usp_serial_port usp_serial_port_asserts u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rxd_o, .rxd_oe, .txd_o);

// ==== verification/usp_serial_port_tb.sv ====
// Purpose: Self-checking bench for the serial port
// Assumes: Rates set for 16 or 32 pclk per bit
// Notes: Random bytes from a fixed seed
`timescale 1ns/100ps
module usp_serial_port_tb;
    import usp_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, rxd_o, rxd_oe, txd_o, drv, rxd_w, perr;
    logic [10:0] got, fr;
    logic [7:0] ctl, d;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    int seed = 52;
    int len, nb;

    assign rxd_w = rxd_oe ? rxd_o : drv;
    always #2 pclk = ~pclk;

    usp_serial_port dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .rxd_i(rxd_w), .rxd_o, .rxd_oe, .txd_o);
    usp_remote_model remote (.pclk, .txd(txd_o), .line(rxd_w), .drv);

    // ==========================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rdat = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rdat, e);
    endtask

    task automatic rxf(input logic [7:0] dd, input logic n9, input logic st);
        remote.send({st, n9, dd, 1'b0}, 11, len);
    endtask

    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            final_report();
        end
    end

    // ==========================================================
    // Scenarios
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(CTRL_OFS, {24'h0, CTRL_RST});
        apb(1'b0, 12'h0b0, 32'h0);
        check({rdat[31:1], perr}, 32'h1);
        for (int m = 0; m < 4; m++)
        begin
            len = (m == 0 || m == 3) ? 32 : 16;
            nb = (m == 1) ? 10 : 11;
            apb(1'b1, PWR_OFS, (m == 0) ? 32'h0 : 32'h80);
            apb(1'b1, BAUD_OFS, (m == 3) ? 32'h1 : 32'h0);
            d = $random(seed);
            ctl = {2'(m) | {m == 0, 1'b0}, 2'b01, 1'($random(seed)), 3'b000};
            apb(1'b1, CTRL_OFS, {24'h0, ctl});
            apb(1'b1, DATA_OFS, {24'h0, d});
            remote.recv(nb, len, got);
            fr = (m == 1) ? {2'b01, d, 1'b0} : {1'b1, ctl[3], d, 1'b0};
            check({21'h0, got}, {21'h0, fr});
            ctl[1] = 1'b1;
            rdchk(CTRL_OFS, {24'h0, ctl});
            d = $random(seed);
            fr = {1'b1, 1'($random(seed)) | (m == 1), d, 1'b0};
            remote.send(fr, nb, len);
            ctl[2:0] = {fr[9], 2'b11};
            rdchk(CTRL_OFS, {24'h0, ctl});
            rdchk(DATA_OFS, {24'h0, d});
            ctl[1:0] = 2'b00;
            apb(1'b1, CTRL_OFS, {24'h0, ctl});
        end
        ctl[5] = 1'b1;
        apb(1'b1, CTRL_OFS, {24'h0, ctl});
        rxf(8'h5a, 1'b0, 1'b1);
        rdchk(CTRL_OFS, {24'h0, ctl});
        rxf(8'ha5, 1'b1, 1'b1);
        ctl[2:0] = 3'b101;
        rdchk(CTRL_OFS, {24'h0, ctl});
        rxf(8'h3c, 1'b1, 1'b1);
        rdchk(DATA_OFS, 32'ha5);
        apb(1'b1, PWR_OFS, 32'hc0);
        rxf(8'h0f, 1'b1, 1'b0);
        rdchk(CTRL_OFS, {24'h0, 1'b1, ctl[6:0]});
        ctl[0] = 1'b0;
        apb(1'b1, CTRL_OFS, {24'h0, 1'b1, ctl[6:0]});
        rxf(8'hf0, 1'b1, 1'b1);
        ctl[0] = 1'b1;
        rdchk(CTRL_OFS, {24'h0, 1'b1, ctl[6:0]});
        ctl[0] = 1'b0;
        apb(1'b1, CTRL_OFS, {24'h0, 1'b0, ctl[6:0]});
        rdchk(CTRL_OFS, {24'h0, 1'b0, ctl[6:0]});
        apb(1'b1, PWR_OFS, 32'h80);
        rdchk(CTRL_OFS, {24'h0, ctl});
        remote.send(11'h000, 1, 6);
        repeat (64) @(posedge pclk);
        rxf(8'h96, 1'b1, 1'b1);
        ctl[0] = 1'b1;
        rdchk(DATA_OFS, 32'h96);
        ctl[4] = 1'b0;
        ctl[0] = 1'b0;
        apb(1'b1, CTRL_OFS, {24'h0, ctl});
        rxf(8'h33, 1'b1, 1'b1);
        rdchk(CTRL_OFS, {24'h0, ctl});
        apb(1'b1, CTRL_OFS, 32'h0);
        d = $random(seed);
        apb(1'b1, DATA_OFS, {24'h0, d});
        remote.recv_shift(got);
        check({21'h0, got}, {24'h0, d});
        repeat (6) @(posedge pclk);
        rdchk(CTRL_OFS, 32'h2);
        d = $random(seed);
        apb(1'b1, CTRL_OFS, 32'h10);
        remote.send_shift(d);
        repeat (4) @(posedge pclk);
        rdchk(CTRL_OFS, 32'h11);
        rdchk(DATA_OFS, {24'h0, d});
        final_report();
    end
endmodule
